// ==== core/fpp_dev.sv ====
// Device end of the parallel configuration port
`timescale 1ns/1ps
module fpp_dev #(
    parameter int POR_CYCLES = fpp_pkg::POR_CYC,
    parameter int USR_INIT_CYCLES = fpp_pkg::USR_INIT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_user_clk_sel,
    input wire logic i_user_io_en,
    input wire logic i_user_startup_clock,
    input wire logic [7:0] i_user_data,
    input wire logic i_user_data_oe,
    output logic [7:0] o_user_data,
    output logic o_user_mode,
    output logic o_cfg_error,
    fpp_link_if.dev lnk
);
    fpp_pkg::fpp_dev_state_t state_ff;
    fpp_pkg::fpp_dev_state_t nxt_state;
    logic [fpp_pkg::CNT_W-1:0] cnt_ff;
    logic [fpp_pkg::CNT_W-1:0] nxt_cnt;
    logic usr_en_ff;
    logic nxt_usr_en;
    logic usr_sel_ff;
    logic io_en_ff;
    logic [fpp_pkg::PIN_W-1:0] pin_s1_ff;
    logic [fpp_pkg::PIN_W-1:0] pin_s2_ff;
    logic [fpp_pkg::PIN_W-1:0] pin_s3_ff;
    logic [fpp_pkg::PIN_W-1:0] pin_ff;
    logic uclk_prev_ff;
    logic uclk_rise;
    logic [2:0] lk_s1_ff;
    logic [2:0] lk_s2_ff;
    logic [2:0] lk_s3_ff;
    logic [2:0] lk_ff;
    logic status_oe_ff;
    logic done_oe_ff;
    logic load_en_ff;
    logic user_mode_ff;
    logic err_ff;
    logic [7:0] data_dev_ff;
    logic data_dev_oe_ff;
    logic [7:0] user_data_ff;
    // Link-domain state
    logic lrst_n;
    logic [fpp_pkg::BYTE_CNT_W-1:0] byte_cnt_ff;
    logic [7:0] xor_ff;
    logic done_l_ff;
    logic err_l_ff;
    logic [1:0] fall_cnt_ff;
    logic fall2_l_ff;

    // Which states drive each open-drain line low
    function automatic logic drives_status(fpp_pkg::fpp_dev_state_t s);
        return s == fpp_pkg::D_POR || s == fpp_pkg::D_RESET
            || s == fpp_pkg::D_ERROR;
    endfunction : drives_status

    function automatic logic drives_done(fpp_pkg::fpp_dev_state_t s);
        return s == fpp_pkg::D_POR || s == fpp_pkg::D_RESET
            || s == fpp_pkg::D_CONFIG || s == fpp_pkg::D_ERROR;
    endfunction : drives_done

    // Three-stage pin sampler; a change counts when stages two and three agree
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_s1_ff <= fpp_pkg::PIN_RST;
            pin_s2_ff <= fpp_pkg::PIN_RST;
            pin_s3_ff <= fpp_pkg::PIN_RST;
            pin_ff <= fpp_pkg::PIN_RST;
        end else begin
            pin_s1_ff <= {lnk.data, i_user_startup_clock, lnk.done,
                lnk.status_n, lnk.cfg_req_n};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_ff <= (pin_s2_ff & pin_s3_ff)
                | (pin_ff & (pin_s2_ff | pin_s3_ff));
        end
    end

    // Start-up clock is only sampled, so it must run well below i_mclk/2
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            uclk_prev_ff <= 1'b0;
        end else begin
            uclk_prev_ff <= pin_ff[fpp_pkg::PIN_UCLK];
        end
    end
    assign uclk_rise = pin_ff[fpp_pkg::PIN_UCLK] && !uclk_prev_ff;

    // Link-domain levels cross into the oscillator domain; like the pins,
    // a change counts only once stages two and three agree
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lk_s1_ff <= 3'h0;
            lk_s2_ff <= 3'h0;
            lk_s3_ff <= 3'h0;
            lk_ff <= 3'h0;
        end else begin
            lk_s1_ff <= {fall2_l_ff, err_l_ff, done_l_ff};
            lk_s2_ff <= lk_s1_ff;
            lk_s3_ff <= lk_s2_ff;
            lk_ff <= (lk_s2_ff & lk_s3_ff) | (lk_ff & (lk_s2_ff | lk_s3_ff));
        end
    end

    // Configuration sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 1'b1;
        nxt_usr_en = usr_en_ff;
        case (state_ff)
            fpp_pkg::D_POR: begin
                if (cnt_ff == fpp_pkg::CNT_W'(POR_CYCLES - 1)) begin
                    nxt_state = fpp_pkg::D_RESET;
                    nxt_cnt = '0;
                end
            end
            fpp_pkg::D_RESET: begin
                if (cnt_ff == fpp_pkg::CNT_W'(fpp_pkg::STATUS_MIN_CYC - 1))
                begin
                    nxt_state = fpp_pkg::D_CONFIG;
                    nxt_cnt = '0;
                end
            end
            fpp_pkg::D_CONFIG: begin
                nxt_cnt = '0;
                if (lk_ff[0] && lk_ff[1]) begin
                    nxt_state = fpp_pkg::D_ERROR;
                end else if (lk_ff[0]) begin
                    nxt_state = fpp_pkg::D_INIT_WAIT;
                end
            end
            fpp_pkg::D_INIT_WAIT: begin
                nxt_cnt = '0;
                nxt_usr_en = 1'b0;
                if (pin_ff[fpp_pkg::PIN_DONE] && lk_ff[2]) begin
                    nxt_state = fpp_pkg::D_INIT;
                end
            end
            fpp_pkg::D_INIT: begin
                if (!usr_sel_ff) begin
                    if (cnt_ff == fpp_pkg::CNT_W'(fpp_pkg::CD2UM_MIN_CYC - 1))
                    begin
                        nxt_state = fpp_pkg::D_USER;
                    end
                end else if (!usr_en_ff) begin
                    if (cnt_ff == fpp_pkg::CNT_W'(fpp_pkg::CD2CU_CYC - 1))
                    begin
                        nxt_usr_en = 1'b1;
                        nxt_cnt = '0;
                    end
                end else begin
                    nxt_cnt = cnt_ff + fpp_pkg::CNT_W'(uclk_rise);
                    if (uclk_rise
                        && cnt_ff == fpp_pkg::CNT_W'(USR_INIT_CYCLES - 1))
                    begin
                        nxt_state = fpp_pkg::D_USER;
                    end
                end
            end
            fpp_pkg::D_USER: begin
                nxt_cnt = '0;
            end
            fpp_pkg::D_ERROR: begin
                // Auto-restart after the status pulse
                if (cnt_ff == fpp_pkg::CNT_W'(fpp_pkg::STATUS_MIN_CYC - 1))
                begin
                    nxt_state = fpp_pkg::D_CONFIG;
                    nxt_cnt = '0;
                end
            end
            default: begin
                nxt_state = fpp_pkg::D_RESET;
                nxt_cnt = '0;
            end
        endcase
        // Request low overrides all but power-on; count waits for release
        if (!pin_ff[fpp_pkg::PIN_REQ] && state_ff != fpp_pkg::D_POR) begin
            nxt_state = fpp_pkg::D_RESET;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= fpp_pkg::D_POR;
            cnt_ff <= '0;
            usr_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            usr_en_ff <= nxt_usr_en;
        end
    end

    // Option straps are caught when leaving power-on, never under reset
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            usr_sel_ff <= 1'b0;
            io_en_ff <= 1'b0;
        end else if (state_ff == fpp_pkg::D_POR) begin
            usr_sel_ff <= i_user_clk_sel;
            io_en_ff <= i_user_io_en;
        end
    end

    // Line drivers follow the next state, so they switch on the same edge as state_ff
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_oe_ff <= 1'b1;
            done_oe_ff <= 1'b1;
            load_en_ff <= 1'b0;
            user_mode_ff <= 1'b0;
        end else begin
            status_oe_ff <= drives_status(nxt_state);
            done_oe_ff <= drives_done(nxt_state);
            // Link logic must live on while the tail falling edges arrive
            load_en_ff <= nxt_state == fpp_pkg::D_CONFIG
                || nxt_state == fpp_pkg::D_INIT_WAIT;
            user_mode_ff <= nxt_state == fpp_pkg::D_USER;
        end
    end

    // Error flag: set wins over the clear taken from a new request
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            err_ff <= 1'b0;
        end else if (nxt_state == fpp_pkg::D_ERROR) begin
            err_ff <= 1'b1;
        end else if (!pin_ff[fpp_pkg::PIN_REQ]) begin
            err_ff <= 1'b0;
        end
    end

    // Data pins turn into user I/O only in user mode
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_dev_ff <= 8'h00;
            data_dev_oe_ff <= 1'b0;
            user_data_ff <= 8'h00;
        end else begin
            data_dev_ff <= i_user_data;
            data_dev_oe_ff <= user_mode_ff && io_en_ff
                && i_user_data_oe;
            user_data_ff <= user_mode_ff ? pin_ff[fpp_pkg::PIN_DATA +: 8]
                : 8'h00;
        end
    end

    // Link logic is held in reset outside the loading window; the host's
    // setup waits guarantee no clock edge near the release
    assign lrst_n = i_arst_n && load_en_ff;

    // Byte capture on the rising link edge; a paused clock just stalls
    always_ff @(posedge lnk.config_byte_clock or negedge lrst_n) begin
        if (!lrst_n) begin
            byte_cnt_ff <= '0;
            xor_ff <= 8'h00;
            done_l_ff <= 1'b0;
            err_l_ff <= 1'b0;
        end else if (!done_l_ff) begin
            byte_cnt_ff <= byte_cnt_ff + 1'b1;
            xor_ff <= xor_ff ^ lnk.data;
            if (byte_cnt_ff == fpp_pkg::BYTE_CNT_W'(fpp_pkg::CFG_BYTES - 1))
            begin
                done_l_ff <= 1'b1;
                err_l_ff <= (xor_ff ^ lnk.data) != 8'h00;
            end
        end
    end

    // Falling edges after completion release initialization
    always_ff @(negedge lnk.config_byte_clock or negedge lrst_n) begin
        if (!lrst_n) begin
            fall_cnt_ff <= 2'h0;
            fall2_l_ff <= 1'b0;
        end else if (done_l_ff && !err_l_ff && !fall2_l_ff) begin
            fall_cnt_ff <= fall_cnt_ff + 1'b1;
            fall2_l_ff <= fall_cnt_ff == 2'h1;
        end
    end

    assign lnk.status_dev_o = 1'b0;
    assign lnk.status_dev_oe = status_oe_ff;
    assign lnk.done_dev_o = 1'b0;
    assign lnk.done_dev_oe = done_oe_ff;
    assign lnk.data_dev = data_dev_ff;
    assign lnk.data_dev_oe = data_dev_oe_ff;
    assign o_user_mode = user_mode_ff;
    assign o_cfg_error = err_ff;
    assign o_user_data = user_data_ff;
endmodule : fpp_dev

// ==== core/fpp_host.sv ====
// Host end of the parallel configuration port
`timescale 1ns/1ps
module fpp_host (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire logic [7:0] i_byte,
    input wire logic i_byte_valid,
    output logic o_byte_ready,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    fpp_link_if.host lnk
);
    fpp_pkg::fpp_host_state_t state_ff;
    logic [fpp_pkg::CNT_W-1:0] cnt_ff;
    logic [fpp_pkg::CNT_W-1:0] gap_ff;
    logic [fpp_pkg::BYTE_CNT_W-1:0] byte_cnt_ff;
    logic [1:0] tail_ff;
    logic clk_ff;
    logic [7:0] data_ff;
    logic data_oe_ff;
    logic done_ff;
    logic err_ff;
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic [1:0] s3_ff;
    logic [1:0] pin_ff;

    // Three-stage sampler for status and completion lines
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_ff <= fpp_pkg::HPIN_RST;
            s2_ff <= fpp_pkg::HPIN_RST;
            s3_ff <= fpp_pkg::HPIN_RST;
            pin_ff <= fpp_pkg::HPIN_RST;
        end else begin
            s1_ff <= {lnk.done, lnk.status_n};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
        end
    end

    // Time since status last rose, saturating
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gap_ff <= '0;
        end else if (!pin_ff[fpp_pkg::HPIN_STAT]) begin
            gap_ff <= '0;
        end else if (gap_ff != '1) begin
            gap_ff <= gap_ff + 1'b1;
        end
    end

    // Sequencer; the byte clock is divided from i_mclk, three cycles a byte
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= fpp_pkg::H_IDLE;
            cnt_ff <= '0;
            byte_cnt_ff <= '0;
            tail_ff <= 2'h0;
            clk_ff <= 1'b0;
            data_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            case (state_ff)
                fpp_pkg::H_IDLE, fpp_pkg::H_END, fpp_pkg::H_ERR: begin
                    clk_ff <= 1'b0;
                    if (i_start) begin
                        state_ff <= fpp_pkg::H_REQ;
                        cnt_ff <= '0;
                    end
                end
                fpp_pkg::H_REQ: begin
                    if (cnt_ff == fpp_pkg::CNT_W'(fpp_pkg::CFG_CYC - 1)) begin
                        state_ff <= fpp_pkg::H_WAIT;
                        cnt_ff <= '0;
                    end
                end
                fpp_pkg::H_WAIT: begin
                    byte_cnt_ff <= '0;
                    if (cnt_ff >= fpp_pkg::CNT_W'(fpp_pkg::CF2CK_CYC)
                        && gap_ff >= fpp_pkg::CNT_W'(fpp_pkg::ST2CK_CYC))
                    begin
                        state_ff <= fpp_pkg::H_LOW;
                    end
                end
                fpp_pkg::H_LOW: begin
                    // Clock held low while no byte is offered
                    if (i_byte_valid) begin
                        data_ff <= i_byte;
                        state_ff <= fpp_pkg::H_SETUP;
                    end
                end
                fpp_pkg::H_SETUP: begin
                    clk_ff <= 1'b1;
                    state_ff <= fpp_pkg::H_HIGH;
                end
                fpp_pkg::H_HIGH: begin
                    clk_ff <= 1'b0;
                    byte_cnt_ff <= byte_cnt_ff + 1'b1;
                    if (byte_cnt_ff
                        == fpp_pkg::BYTE_CNT_W'(fpp_pkg::CFG_BYTES - 1)) begin
                        state_ff <= fpp_pkg::H_DONE;
                    end else begin
                        state_ff <= fpp_pkg::H_LOW;
                    end
                end
                fpp_pkg::H_DONE: begin
                    tail_ff <= 2'h0;
                    if (pin_ff[fpp_pkg::HPIN_DONE]) begin
                        state_ff <= fpp_pkg::H_TAIL;
                    end
                end
                fpp_pkg::H_TAIL: begin
                    clk_ff <= !clk_ff;
                    tail_ff <= tail_ff + 1'b1;
                    if (tail_ff == 2'h3) begin
                        state_ff <= fpp_pkg::H_END;
                    end
                end
                default: begin
                    state_ff <= fpp_pkg::H_IDLE;
                end
            endcase
            // Status low while loading is a reported data error
            if (!pin_ff[fpp_pkg::HPIN_STAT] && (state_ff == fpp_pkg::H_LOW
                || state_ff == fpp_pkg::H_DONE)) begin
                state_ff <= fpp_pkg::H_ERR;
                clk_ff <= 1'b0;
            end
        end
    end

    // Outcome flags; a new start clears them, the bus goes quiet when done
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            data_oe_ff <= 1'b0;
        end else begin
            done_ff <= state_ff == fpp_pkg::H_END;
            err_ff <= state_ff == fpp_pkg::H_ERR;
            data_oe_ff <= state_ff == fpp_pkg::H_LOW
                || state_ff == fpp_pkg::H_SETUP
                || state_ff == fpp_pkg::H_HIGH;
        end
    end

    assign lnk.cfg_req_n = state_ff != fpp_pkg::H_REQ;
    assign lnk.config_byte_clock = clk_ff;
    assign lnk.data_host = data_ff;
    assign lnk.data_host_oe = data_oe_ff;
    assign lnk.status_host_o = 1'b0;
    assign lnk.status_host_oe = 1'b0;
    assign o_byte_ready = state_ff == fpp_pkg::H_LOW;
    assign o_busy = state_ff != fpp_pkg::H_IDLE
        && state_ff != fpp_pkg::H_END && state_ff != fpp_pkg::H_ERR;
    assign o_done = done_ff;
    assign o_error = err_ff;
endmodule : fpp_host

// ==== dv/fpp_asserts.sv ====
// Link timing checks for the parallel configuration port
`timescale 1ns/1ps
module fpp_asserts #(
    parameter int POR_CYCLES = 50
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic cfg_req_n,
    input wire logic config_byte_clock,
    input wire logic [7:0] data,
    input wire logic status_n,
    input wire logic status_dev_oe,
    input wire logic done
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    int age_ff;
    int rel_ff;
    int st_ff;
    int lo_ff;
    int rise_ff;
    // Saturating counters, so a long idle span never wraps
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            age_ff <= 0;
            rel_ff <= 0;
            st_ff <= 0;
            lo_ff <= 0;
        end else begin
            age_ff <= (age_ff < 9000) ? age_ff + 1 : age_ff;
            rel_ff <= !cfg_req_n ? 0 : (rel_ff < 9000) ? rel_ff + 1 : rel_ff;
            st_ff <= !status_n ? 0 : (st_ff < 9000) ? st_ff + 1 : st_ff;
            lo_ff <= !status_dev_oe ? 0 : (lo_ff < 9000) ? lo_ff + 1 : lo_ff;
        end
    end
    // Byte clock rises since the last request
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) rise_ff <= 0;
        else if (!cfg_req_n) rise_ff <= 0;
        else if ($rose(config_byte_clock)) rise_ff <= rise_ff + 1;
    end
    req_done_low_a: assert property (
        $fell(cfg_req_n) |-> ##[0:8] !done) else $error("done not low");
    req_status_low_a: assert property (
        $fell(cfg_req_n) |-> ##[0:8] !status_n) else $error("status not low");
    por_hold_a: assert property (
        age_ff < POR_CYCLES |-> !status_n) else $error("status early");
    status_release_a: assert property (
        $rose(cfg_req_n) |-> ##[1:1000] !status_dev_oe)
        else $error("status not released");
    pulse_width_a: assert property (
        $fell(status_dev_oe) && age_ff > POR_CYCLES + 4 |-> lo_ff >= 100)
        else $error("status pulse short");
    pulse_max_a: assert property (
        $rose(status_dev_oe) |-> ##[1:1000] !status_dev_oe)
        else $error("status pulse long");
    first_rise_a: assert property (
        $rose(config_byte_clock) && rise_ff == 0
        |-> rel_ff >= 1000 && st_ff >= 20) else $error("first edge early");
    data_setup_a: assert property (
        $rose(config_byte_clock) && !done |-> $stable(data))
        else $error("data moved at edge");
    clock_pause_a: assert property (
        $rose(config_byte_clock) |=> !config_byte_clock)
        else $error("clock held high");
    done_bytes_a: assert property (
        $rose(done) |-> rise_ff == 16) else $error("done early");
    two_falls_a: assert property (
        $rose(done) |-> ##[1:30] $fell(config_byte_clock)
        ##[1:4] $fell(config_byte_clock)) else $error("no tail falls");
endmodule : fpp_asserts

// ==== dv/tb_top.sv ====
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic uclk = 1'b0;
    logic i_start = 1'b0;
    logic [7:0] i_byte = 8'h00;
    logic i_byte_valid = 1'b0;
    logic clk_sel = 1'b0;
    logic [7:0] udata = 8'h00;
    logic udata_oe = 1'b0;
    logic io_en = 1'b1;
    logic o_byte_ready, o_busy, o_done, o_error;
    logic [7:0] o_user_data;
    logic o_user_mode, o_cfg_error;
    logic [31:0] seed = 32'hd14ae332;
    int mismatches = 0;
    int check_count = 0;
    int n;
    fpp_link_if lnk ();
    fpp_dev #(.POR_CYCLES(50), .USR_INIT_CYCLES(8)) fpp_dev_i (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_user_clk_sel(clk_sel),
        .i_user_io_en(io_en), .i_user_startup_clock(uclk),
        .i_user_data(udata), .i_user_data_oe(udata_oe),
        .o_user_data(o_user_data), .o_user_mode(o_user_mode),
        .o_cfg_error(o_cfg_error), .lnk(lnk));
    fpp_host fpp_host_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_start(i_start), .i_byte(i_byte), .i_byte_valid(i_byte_valid),
        .o_byte_ready(o_byte_ready), .o_busy(o_busy), .o_done(o_done),
        .o_error(o_error), .lnk(lnk));
    fpp_asserts #(.POR_CYCLES(50)) fpp_asserts_i (.i_mclk(i_mclk),
        .i_arst_n(i_arst_n), .cfg_req_n(lnk.cfg_req_n),
        .config_byte_clock(lnk.config_byte_clock), .data(lnk.data),
        .status_n(lnk.status_n), .status_dev_oe(lnk.status_dev_oe),
        .done(lnk.done));
    // Start-up clock kept well below the rate the device can sample
    always #50 i_mclk = ~i_mclk;
    always #200 uclk = ~uclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // Full image; a nonzero fix spoils the closing byte of the sum
    task automatic run_cfg(input logic [7:0] fix);
        logic [7:0] x;
        x = 8'h00;
        @(posedge i_mclk);
        i_start <= 1'b1;
        @(posedge i_mclk);
        i_start <= 1'b0;
        for (int k = 0; k < fpp_pkg::CFG_BYTES; k++) begin
            seed = lfsr(seed);
            i_byte <= (k == fpp_pkg::CFG_BYTES - 1) ? x ^ fix : seed[7:0];
            x = x ^ seed[7:0];
            i_byte_valid <= 1'b1;
            n = 0;
            do begin
                @(posedge i_mclk);
                n++;
            end while (o_byte_ready !== 1'b1 && n < 3000);
            if (k == 0) chk("host_busy", 8'h1, o_busy);
        end
        i_byte_valid <= 1'b0;
        n = 0;
        while (o_done !== 1'b1 && o_error !== 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        // A hung host stays busy, so this also catches a run out of time
        chk("host_idle", 8'h0, o_busy);
    endtask : run_cfg
    task automatic wait_user();
        n = 0;
        while (o_user_mode !== 1'b1 && n < 1000) begin
            @(posedge i_mclk);
            n++;
        end
    endtask : wait_user
    initial begin
        repeat (20000) @(posedge i_mclk);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (10) @(posedge i_mclk);
        chk("por_status", 8'h0, lnk.status_n);
        chk("por_done", 8'h0, lnk.done);
        $display("test power_on ended");
        run_cfg(8'h00);
        chk("host_done", 8'h1, o_done);
        wait_user();
        chk("init_window", 8'h1, n >= 190 && n <= 990);
        chk("user_pins", 8'h7, {lnk.cfg_req_n, lnk.status_n, lnk.done});
        seed = lfsr(seed);
        udata <= seed[7:0];
        udata_oe <= 1'b1;
        // Output flop, three-stage sampler and result flop lie in the way
        repeat (8) @(posedge i_mclk);
        chk("user_io", udata, o_user_data);
        udata_oe <= 1'b0;
        $display("test good_image ended");
        run_cfg(8'h5a);
        chk("restart", 8'h0, o_user_mode);
        chk("host_err", 8'h1, o_error);
        chk("dev_err", 8'h1, o_cfg_error);
        chk("err_done", 8'h0, lnk.done);
        $display("test bad_image ended");
        run_cfg(8'h00);
        chk("err_clear", 8'h0, o_cfg_error);
        // Option straps are only taken in power-on, so reset mid-run
        clk_sel <= 1'b1;
        io_en <= 1'b0;
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        chk("rst_done", 8'h0, lnk.done);
        run_cfg(8'h00);
        wait_user();
        chk("usr_clk_init", 8'h1, n < 100 && o_user_mode === 1'b1);
        udata_oe <= 1'b1;
        repeat (8) @(posedge i_mclk);
        chk("io_off", 8'hff, o_user_data);
        $display("test startup_clock ended");
        summarize();
    end
endmodule : tb_top

// ==== pkg/fpp_link_if.sv ====
// Pin-level link between configuration host and device
`timescale 1ns/1ps
interface fpp_link_if;
    logic cfg_req_n;
    logic config_byte_clock;
    logic [7:0] data_host;
    logic data_host_oe;
    logic [7:0] data_dev;
    logic data_dev_oe;
    logic status_dev_o;
    logic status_dev_oe;
    logic status_host_o;
    logic status_host_oe;
    logic done_dev_o;
    logic done_dev_oe;
    // Resolved wire levels; open-drain lines rest high via pull-up
    logic status_n;
    logic done;
    logic [7:0] data;

    assign status_n = !((status_dev_oe && !status_dev_o)
        || (status_host_oe && !status_host_o));
    assign done = !(done_dev_oe && !done_dev_o);
    // Host wins a clash; an undriven bus reads as pulled high
    assign data = data_host_oe ? data_host
        : (data_dev_oe ? data_dev : 8'hff);

    modport dev (
        input cfg_req_n, config_byte_clock, data, status_n, done,
        output data_dev, data_dev_oe, status_dev_o, status_dev_oe,
        output done_dev_o, done_dev_oe
    );
    modport host (
        output cfg_req_n, config_byte_clock, data_host, data_host_oe,
        output status_host_o, status_host_oe,
        input status_n, done, data
    );
endinterface : fpp_link_if

// ==== pkg/fpp_pkg.sv ====
// Shared constants and state types for the parallel configuration port
package fpp_pkg;
    // Local oscillator period and counter width
    localparam int MCLK_PERIOD_NS = 100;
    localparam int CNT_W = 17;
    // Bytes in one configuration image; the last byte zeroes the XOR sum
    localparam int CFG_BYTES = 16;
    localparam int BYTE_CNT_W = 5;
    // Fastest link clock period, in ns
    localparam int T_CLK_MIN_NS = 10;
    // Timing figures in their own units
    localparam int T_POR_MS = 12;
    localparam int T_CFG_US = 2;
    localparam int T_STATUS_MIN_US = 10;
    localparam int T_CF2CK_US = 100;
    localparam int T_ST2CK_US = 2;
    localparam int T_CD2UM_MIN_US = 20;
    localparam int T_CD2CU_NS = 4 * T_CLK_MIN_NS;
    // Least times rounded up to whole local clock cycles
    localparam int POR_CYC = (T_POR_MS * 1000000 + MCLK_PERIOD_NS - 1)
        / MCLK_PERIOD_NS;
    localparam int CFG_CYC = (T_CFG_US * 1000 + MCLK_PERIOD_NS - 1)
        / MCLK_PERIOD_NS;
    localparam int STATUS_MIN_CYC = (T_STATUS_MIN_US * 1000
        + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CF2CK_CYC = (T_CF2CK_US * 1000 + MCLK_PERIOD_NS - 1)
        / MCLK_PERIOD_NS;
    localparam int ST2CK_CYC = (T_ST2CK_US * 1000 + MCLK_PERIOD_NS - 1)
        / MCLK_PERIOD_NS;
    localparam int CD2UM_MIN_CYC = (T_CD2UM_MIN_US * 1000
        + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CD2CU_CYC = (T_CD2CU_NS + MCLK_PERIOD_NS - 1)
        / MCLK_PERIOD_NS;
    // Start-up clock cycles needed before user mode
    localparam int USR_INIT_CYC = 4436;
    // Device pin synchroniser layout and reset value
    localparam int PIN_W = 12;
    localparam int PIN_REQ = 0;
    localparam int PIN_STAT = 1;
    localparam int PIN_DONE = 2;
    localparam int PIN_UCLK = 3;
    localparam int PIN_DATA = 4;
    localparam logic [11:0] PIN_RST = 12'h001;
    // Host pin synchroniser layout
    localparam int HPIN_STAT = 0;
    localparam int HPIN_DONE = 1;
    localparam logic [1:0] HPIN_RST = 2'h0;

    typedef enum logic [2:0] {
        D_POR, D_RESET, D_CONFIG, D_INIT_WAIT, D_INIT, D_USER, D_ERROR
    } fpp_dev_state_t;

    typedef enum logic [3:0] {
        H_IDLE, H_REQ, H_WAIT, H_LOW, H_SETUP, H_HIGH, H_DONE, H_TAIL,
        H_END, H_ERR
    } fpp_host_state_t;
endpackage : fpp_pkg
